// ===== core/sdc_dev.sv
// Conversion sequencer and fourth-order sinc decimator of a delta-sigma ADC.
// Assumes a 1-bit modulator stream on a pin and a controller on the link.
// Function
// RULE_01 - Four modes: single, continuous, multi, turbo
// RULE_02 - Start by control bit or start input
// RULE_03 - Done sets status, output high until read
// RULE_04 - Single: four conversions, first three prime
// RULE_05 - Single: back to standby after read
// RULE_06 - Continuous: three priming periods, then every period
// RULE_07 - Multi: re-prime before each sample, auto restart
// RULE_08 - Mux change: invalid until fourth sample after
// RULE_09 - 12-bit or faster 8-bit resolution
// RULE_10 - Serial modulator stream to parallel words
// RULE_11 - Fourth-order sinc response
// RULE_12 - Done output drives interrupt or DMA request
// RULE_13 - System polls status or uses done signal
// RULE_14 - Start input optional in continuous mode
// RULE_15 - External trigger drives start input
// RULE_16 - No switched inputs in continuous mode
// RULE_17 - Start ignored while sequence runs
// RULE_18 - Turbo follows multi sample sequencing
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sdc_dev
  import sdc_pkg::*;
(
  input  wire logic i_clk,      // System clock
  input  wire logic i_srst,     // Synchronous reset, active high
  input  wire logic i_mod_bit,  // Modulator bit stream
  output var  logic o_mod_ce,   // Modulator sample strobe
  sdc_if.dev        sb          // Link to controller
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } sdc_state_t;

  sdc_state_t        state;
  sdc_state_t        next_state;
  sdc_mode_t         mode_q;
  logic              res8_q;
  logic [2:0]        mod_sync;
  logic              mod_lvl;
  logic [DIV_W-1:0]  div_cnt;
  logic [5:0]        dcnt;
  logic [5:0]        osr_last;
  logic [2:0]        conv_cnt;
  logic              running;
  logic              start_ok;
  logic              tick;
  logic              res_ev;
  logic              restart;
  logic              cic_clr;
  logic [ACC_W-1:0]  integ [CIC_ORDER];
  logic [ACC_W-1:0]  dly   [CIC_ORDER];
  logic [ACC_W-1:0]  comb_v [CIC_ORDER+1];

  function automatic logic [RES_W-1:0] sat_res(input logic [ACC_W-1:0] v, input logic r8);
    logic [ACC_W-1:0] sh;
    logic [RES_W-1:0] mx;
    sh = v >> OUT_SHIFT;
    mx = r8 ? RES8_MAX : RES12_MAX;
    sat_res = (sh > ACC_W'(mx)) ? mx : sh[RES_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Modulator pin synchroniser and sample strobe
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mod_sync <= 3'h0;
    end else begin
      mod_sync <= {mod_sync[1:0], i_mod_bit};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mod_lvl <= 1'b0;
    end else if (mod_sync[1] == mod_sync[2]) begin
      mod_lvl <= mod_sync[2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_cnt  <= '0;
      o_mod_ce <= 1'b0;
    end else begin
      o_mod_ce <= (div_cnt == DIV_W'(MOD_DIV - 1));
      div_cnt  <= (div_cnt == DIV_W'(MOD_DIV - 1)) ? '0 : div_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing terms
  always_comb begin
    running  = (state != ST_IDLE);
    osr_last = res8_q ? OSR8_LAST : OSR12_LAST;                  // RULE_09
    start_ok = sb.soc && sb.run_en && (state == ST_IDLE);      // RULE_02 RULE_17 RULE_14
    tick     = (state == ST_RUN) && o_mod_ce && (dcnt == osr_last);
    res_ev   = tick && !sb.mux_chg && (conv_cnt == PRIME_LAST);   // RULE_04 RULE_06
    restart  = res_ev && ((mode_q == MODE_MULTI) || (mode_q == MODE_TURBO)); // RULE_07 RULE_18
    cic_clr  = start_ok || restart;                            // RULE_07
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mode_q <= MODE_SINGLE;
      res8_q <= 1'b0;
    end else if (start_ok) begin
      mode_q <= sb.mode;                                       // RULE_01
      res8_q <= sb.res8;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decimator: four integrators at modulator rate, four combs per conversion
  always_ff @(posedge i_clk) begin
    if (i_srst || cic_clr) begin
      for (int k = 0; k < CIC_ORDER; k++) begin
        integ[k] <= '0;
      end
    end else if (running && o_mod_ce) begin
      integ[0] <= integ[0] + {{(ACC_W-1){1'b0}}, mod_lvl};      // RULE_10
      for (int k = 1; k < CIC_ORDER; k++) begin
        integ[k] <= integ[k] + integ[k-1];                     // RULE_11
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || cic_clr) begin
      dcnt <= 6'h0;
    end else if (running && o_mod_ce) begin
      dcnt <= (dcnt == osr_last) ? 6'h0 : dcnt + 6'h1;
    end
  end

  always_comb begin
    comb_v[0] = integ[CIC_ORDER-1];
    for (int k = 0; k < CIC_ORDER; k++) begin
      comb_v[k+1] = comb_v[k] - dly[k];                        // RULE_11
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || cic_clr) begin
      for (int k = 0; k < CIC_ORDER; k++) begin
        dly[k] <= '0;
      end
    end else if (tick) begin
      for (int k = 0; k < CIC_ORDER; k++) begin
        dly[k] <= comb_v[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Priming count; a mux change restarts priming but leaves the pipeline contents in place
  always_ff @(posedge i_clk) begin
    if (i_srst || cic_clr) begin
      conv_cnt <= 3'h0;
    end else if (sb.mux_chg) begin
      conv_cnt <= 3'h0;                                        // RULE_08
    end else if (tick && conv_cnt != PRIME_LAST) begin
      conv_cnt <= conv_cnt + 3'h1;                             // RULE_04 RULE_06
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result word and end of conversion
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sb.result <= '0;
    end else if (res_ev) begin
      sb.result <= sat_res(comb_v[CIC_ORDER], res8_q);         // RULE_09 RULE_10
    end
  end

  // New result wins over a read in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sb.eoc <= 1'b0;
    end else if (res_ev) begin
      sb.eoc <= 1'b1;                                          // RULE_03 RULE_12
    end else if (sb.rd) begin
      sb.eoc <= 1'b0;                                          // RULE_03
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!sb.run_en) begin
          next_state = ST_IDLE;
        end else if (res_ev && mode_q == MODE_SINGLE) begin
          next_state = ST_HOLD;                                // RULE_04
        end
      end
      ST_HOLD: begin
        if (!sb.run_en || !sb.eoc) begin
          next_state = ST_IDLE;                                // RULE_05
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state   <= ST_IDLE;
      sb.busy <= 1'b0;
    end else begin
      state   <= next_state;
      sb.busy <= (next_state != ST_IDLE);
    end
  end

endmodule
`default_nettype wire

// ===== core/sdc_pkg.sv
// Shared constants and types of the conversion sequencer and its controller.
// Assumes a single 100 MHz system clock at both ends.
package sdc_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_CONT   = 2'b01,
    MODE_MULTI  = 2'b10,
    MODE_TURBO  = 2'b11
  } sdc_mode_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int MOD_CLK_HZ = 12_500_000;
  localparam int MOD_DIV    = SYS_CLK_HZ / MOD_CLK_HZ;
  localparam int DIV_W      = $clog2(MOD_DIV);

  ////////////////////////////////////////////////////////////////////////////////
  // Decimator
  localparam int             RES_W      = 12;
  localparam int             CIC_ORDER  = 4;
  localparam int             ACC_W      = 25;
  localparam int             OUT_SHIFT  = 12;
  localparam logic [5:0]     OSR12_LAST = 6'h3f;
  localparam logic [5:0]     OSR8_LAST  = 6'h1f;
  localparam logic [11:0]    RES12_MAX  = 12'hfff;
  localparam logic [11:0]    RES8_MAX   = 12'h0ff;
  localparam logic [2:0]     PRIME_LAST = 3'h3;
  localparam int             MUX_W      = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int          ADR_W        = 5;
  localparam logic [4:0]  REG_CTRL     = 5'h00;
  localparam logic [4:0]  REG_STATUS   = 5'h04;
  localparam logic [4:0]  REG_RESULT   = 5'h08;
  localparam logic [4:0]  REG_MUX      = 5'h0c;
  localparam logic [4:0]  REG_IRQ_STAT = 5'h10;
  localparam logic [4:0]  REG_IRQ_CLR  = 5'h14;
  localparam logic [4:0]  REG_IRQ_EN   = 5'h18;

  localparam int CTRL_START   = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_MODE_HI = 2;
  localparam int CTRL_RES8    = 3;
  localparam int CTRL_EN      = 4;
  localparam int CTRL_TRIG_EN = 5;
  localparam int STAT_DONE    = 0;
  localparam int STAT_BUSY    = 1;
  localparam int IRQ_DONE     = 0;

  localparam logic [1:0]       MODE_RST   = 2'h0;
  localparam logic [MUX_W-1:0] MUX_RST    = 4'h0;
  localparam logic             IRQ_EN_RST = 1'b0;

endpackage

// ===== core/sdc_if.sv
// Link between the conversion sequencer and its bus-side controller.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface sdc_if;
  import sdc_pkg::*;
  logic              soc;      // Start of conversion, one-cycle pulse
  logic              run_en;   // Converter enabled
  sdc_mode_t         mode;     // Operating mode
  logic              res8;     // 8-bit fast resolution
  logic              mux_chg;  // Input mux changed, one-cycle pulse
  logic              rd;       // Result read, one-cycle pulse
  logic              eoc;      // End of conversion, level
  logic              busy;     // Sequence in progress
  logic [RES_W-1:0]  result;   // Conversion result
  modport dev  (input soc, run_en, mode, res8, mux_chg, rd, output eoc, busy, result);
  modport host (output soc, run_en, mode, res8, mux_chg, rd, input eoc, busy, result);
endinterface
`default_nettype wire

// ===== core/sdc_host.sv
// Bus-side controller: Wishbone registers, trigger pin, mux select, interrupt.
// Assumes a classic Wishbone master and the sequencer on the link.
`timescale 1ns/1ps
`default_nettype none
module sdc_host
  import sdc_pkg::*;
(
  input  wire logic              i_clk,     // System clock
  input  wire logic              i_srst,    // Synchronous reset, active high
  input  wire logic              i_wb_cyc,  // Wishbone cycle
  input  wire logic              i_wb_stb,  // Wishbone strobe
  input  wire logic              i_wb_we,   // Wishbone write enable
  input  wire logic [ADR_W-1:0]  i_wb_adr,  // Wishbone byte address
  input  wire logic [3:0]        i_wb_sel,  // Wishbone byte selects
  input  wire logic [31:0]       i_wb_dat,  // Wishbone write data
  output var  logic [31:0]       o_wb_dat,  // Wishbone read data
  output var  logic              o_wb_ack,  // Wishbone acknowledge
  input  wire logic              i_trig,    // External start trigger pin
  output var  logic [MUX_W-1:0]  o_mux_sel, // Analog input mux select
  output var  logic              o_eoc,     // Done, for DMA request
  output var  logic              o_irq,     // Interrupt, level
  sdc_if.host                    sb         // Link to sequencer
);

  logic       req;
  logic       wr;
  logic       rd;
  logic       trig_en;
  logic [2:0] trig_sync;
  logic       trig_lvl;
  logic       trig_rise;
  logic       eoc_q;
  logic       irq_stat;
  logic       irq_en;

  always_comb begin
    req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wr  = req && i_wb_we && i_wb_sel[0];
    rd  = req && !i_wb_we;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger pin synchroniser
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      trig_sync <= 3'h0;
    end else begin
      trig_sync <= {trig_sync[1:0], i_trig};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      trig_lvl <= 1'b0;
    end else if (trig_sync[1] == trig_sync[2]) begin
      trig_lvl <= trig_sync[2];
    end
  end

  assign trig_rise = (trig_sync[1] == trig_sync[2]) && trig_sync[2] && !trig_lvl;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register and start pulse
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sb.mode   <= sdc_mode_t'(MODE_RST);
      sb.res8   <= 1'b0;
      sb.run_en <= 1'b0;
      trig_en   <= 1'b0;
    end else if (wr && i_wb_adr == REG_CTRL) begin
      sb.mode   <= sdc_mode_t'(i_wb_dat[CTRL_MODE_HI:CTRL_MODE_LO]);
      sb.res8   <= i_wb_dat[CTRL_RES8];
      sb.run_en <= i_wb_dat[CTRL_EN];
      trig_en   <= i_wb_dat[CTRL_TRIG_EN];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sb.soc <= 1'b0;
    end else begin
      sb.soc <= (wr && i_wb_adr == REG_CTRL && i_wb_dat[CTRL_START])
             || (trig_en && trig_rise);                        // RULE_02 RULE_15
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input mux select
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_mux_sel  <= MUX_RST;
      sb.mux_chg <= 1'b0;
    end else begin
      sb.mux_chg <= wr && i_wb_adr == REG_MUX && i_wb_dat[MUX_W-1:0] != o_mux_sel;
      if (wr && i_wb_adr == REG_MUX) begin
        o_mux_sel <= i_wb_dat[MUX_W-1:0];                      // RULE_16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, clear and enable; set wins over clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      eoc_q    <= 1'b0;
      irq_stat <= 1'b0;
      irq_en   <= IRQ_EN_RST;
      o_irq    <= 1'b0;
      o_eoc    <= 1'b0;
    end else begin
      eoc_q <= sb.eoc;
      o_eoc <= sb.eoc;                                         // RULE_12
      if (sb.eoc && !eoc_q) begin
        irq_stat <= 1'b1;                                      // RULE_13
      end else if (wr && i_wb_adr == REG_IRQ_CLR && i_wb_dat[IRQ_DONE]) begin
        irq_stat <= 1'b0;
      end
      if (wr && i_wb_adr == REG_IRQ_EN) begin
        irq_en <= i_wb_dat[IRQ_DONE];
      end
      o_irq <= irq_stat && irq_en;                             // RULE_12
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer; reading the result releases the done flag
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
      sb.rd    <= 1'b0;
    end else begin
      o_wb_ack <= req;
      sb.rd    <= rd && i_wb_adr == REG_RESULT;                // RULE_03
      o_wb_dat <= 32'h0;
      if (rd) begin
        if (i_wb_adr == REG_CTRL) begin
          o_wb_dat <= 32'({trig_en, sb.run_en, sb.res8, sb.mode, 1'b0});
        end else if (i_wb_adr == REG_STATUS) begin
          o_wb_dat <= 32'({sb.busy, sb.eoc});                  // RULE_13
        end else if (i_wb_adr == REG_RESULT) begin
          o_wb_dat <= 32'(sb.result);
        end else if (i_wb_adr == REG_MUX) begin
          o_wb_dat <= 32'(o_mux_sel);
        end else if (i_wb_adr == REG_IRQ_STAT) begin
          o_wb_dat <= 32'(irq_stat);
        end else if (i_wb_adr == REG_IRQ_EN) begin
          o_wb_dat <= 32'(irq_en);
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== verification/sdc_props.sv
// Checker for the link between sequencer and controller.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module sdc_props
  import sdc_pkg::*;
(
  input wire logic             i_clk,   // System clock
  input wire logic             i_srst,  // Sync reset
  input wire logic             soc,     // Start pulse
  input wire logic             run_en,  // Enable
  input wire sdc_mode_t        mode,    // Mode
  input wire logic             res8,    // Fast resolution
  input wire logic             mux_chg, // Mux change pulse
  input wire logic             rd,      // Result read pulse
  input wire logic             eoc,     // Done level
  input wire logic             busy,    // Sequence running
  input wire logic [RES_W-1:0] result   // Result word
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle counters since start, last result and last mux change
  logic [11:0] t_run;
  logic [11:0] t_gap;
  logic [11:0] t_mux;
  logic        gap_ok;

  always_ff @(posedge i_clk) begin
    if (i_srst || !busy) t_run <= 12'h000;
    else if (t_run != 12'hfff) t_run <= t_run + 12'h001;
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) t_gap <= 12'h000;
    else if ($rose(eoc)) t_gap <= 12'h001;
    else if (t_gap != 12'hfff) t_gap <= t_gap + 12'h001;
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) t_mux <= 12'hfff;
    else if (mux_chg) t_mux <= 12'h000;
    else if (t_mux != 12'hfff) t_mux <= t_mux + 12'h001;
  end
  // A period is only measured between two results of one unbroken run
  always_ff @(posedge i_clk) begin
    if (i_srst || !busy || soc || mux_chg) gap_ok <= 1'b0;
    else if ($rose(eoc)) gap_ok <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_eoc_holds: assert property (eoc && !rd && run_en |=> eoc)
    else $error("done dropped without a read");
  a_read_clears: assert property (rd && eoc && mode == MODE_SINGLE |=> !eoc)
    else $error("done still high after read");
  a_back_idle: assert property (rd && eoc && mode == MODE_SINGLE |-> ##[1:4] !busy)
    else $error("single run did not return to standby");
  a_start_busy: assert property (soc && run_en && !busy |=> busy)
    else $error("start did not begin a sequence");
  a_start_kept: assert property (soc && busy |=> busy)
    else $error("start during a sequence upset it");
  a_first_time: assert property ($rose(eoc) && !gap_ok && t_mux == 12'hfff |->
    (res8 ? (t_run >= 12'h3f2 && t_run <= 12'h41a) : (t_run >= 12'h7ee && t_run <= 12'h816)))
    else $error("first result not after four conversions");
  a_cont_period: assert property ($rose(eoc) && gap_ok && mode == MODE_CONT |->
    (res8 ? (t_gap >= 12'h0fc && t_gap <= 12'h104) : (t_gap >= 12'h1fc && t_gap <= 12'h204)))
    else $error("continuous result period wrong");
  a_multi_period: assert property ($rose(eoc) && gap_ok && mode[1] |->
    (res8 ? (t_gap >= 12'h3f0 && t_gap <= 12'h410) : (t_gap >= 12'h7f0 && t_gap <= 12'h830)))
    else $error("multi sample result not re-primed");
  a_mux_settle: assert property ($rose(eoc) && t_mux > 12'h008 && t_mux < 12'h898 |->
    t_mux >= (res8 ? 12'h2f8 : 12'h5fa))
    else $error("result too soon after mux change");
  a_res8_range: assert property (eoc && busy && res8 |-> result <= RES8_MAX)
    else $error("fast result above its range");

  c_single: cover property ($rose(eoc) && mode == MODE_SINGLE);
  c_cont: cover property ($rose(eoc) && gap_ok && mode == MODE_CONT);
  c_turbo: cover property ($rose(eoc) && gap_ok && mode == MODE_TURBO);
  c_ignored: cover property (soc && busy);
endmodule
`default_nettype wire

// ===== verification/sdc_test.sv
// Bench joining sequencer and controller, driven over Wishbone.
// Assumes constant modulator levels give full-scale or zero results.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  cmp_count++; \
  if ((a) !== (b)) begin \
    failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module sdc_test;
  import sdc_pkg::*;
  logic        clk;
  logic        srst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        trig;
  logic        mod_bit;
  logic        ack;
  logic        eoc_o;
  logic        irq;
  logic        mod_ce;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [3:0]  mux_sel;
  logic [3:0]  mux_v;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  int          failures;
  int          cmp_count;
  int          seed;
  int          n_ce;
  int          exp_q[$];
  logic [4:0]  regs[7] = '{REG_CTRL, REG_STATUS, REG_RESULT, REG_MUX, REG_IRQ_STAT,
                           REG_IRQ_EN, 5'h1c};

  sdc_if link ();
  sdc_dev i_sdc_dev (.i_clk(clk), .i_srst(srst), .i_mod_bit(mod_bit), .o_mod_ce(mod_ce),
    .sb(link.dev));
  sdc_host i_sdc_host (.i_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_trig(trig), .o_mux_sel(mux_sel), .o_eoc(eoc_o), .o_irq(irq),
    .sb(link.host));
  sdc_props i_sdc_props (.i_clk(clk), .i_srst(srst), .soc(link.soc), .run_en(link.run_en),
    .mode(link.mode), .res8(link.res8), .mux_chg(link.mux_chg), .rd(link.rd),
    .eoc(link.eoc), .busy(link.busy), .result(link.result));

  ////////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic end_sim();
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Classic single cycle; read data lands in q
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      failures++;
      end_sim();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_eoc();
    int n;
    n = 0;
    while (eoc_o !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) begin
      failures++;
      end_sim();
    end
  endtask

  // One run of a mode; the model expects full scale or zero per level
  task automatic run(input sdc_mode_t m, input logic r8, input logic tg, input int nres);
    logic [31:0] ctrl;
    logic        ien;
    int          lvl;
    int          e;
    lvl = $random(seed) & 1;
    mod_bit <= 1'(lvl);
    ien = (m == MODE_SINGLE);
    ctrl = {26'h0, tg, 1'b1, r8, m, ~tg};
    bus(1'b1, REG_IRQ_EN, {31'h0, ien});
    bus(1'b1, REG_CTRL, ctrl);
    if (tg) begin
      trig <= 1'b1;
      repeat (6) @(posedge clk);
      trig <= 1'b0;
    end
    repeat (700) @(posedge clk);
    bus(1'b1, REG_CTRL, ctrl | 32'h1);
    for (int k = 0; k < nres; k++) begin
      exp_q.push_back(lvl != 0 ? (r8 ? 32'hff : 32'hfff) : 32'h0);
      wait_eoc();
      bus(1'b0, REG_STATUS, 32'h0);
      `CHK(q, 32'h3)
      `CHK(irq, ien)
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      `CHK(q, 32'h1)
      // Switched inputs belong to multi sample; the change lands mid-priming
      if (m == MODE_MULTI && k == 0) begin
        repeat (700) @(posedge clk);
        mux_v = mux_v ^ (4'($random(seed)) | 4'h1);
        bus(1'b1, REG_MUX, {28'h0, mux_v});
        `CHK(mux_sel, mux_v)
      end
      bus(1'b0, REG_RESULT, 32'h0);
      e = exp_q.pop_front();
      `CHK(q, 32'(e))
      bus(1'b1, REG_IRQ_CLR, 32'h1);
      repeat (4) @(posedge clk);
      `CHK(irq, 1'b0)
    end
    if (m != MODE_SINGLE) begin
      bus(1'b1, REG_CTRL, 32'h0);
      repeat (4) @(posedge clk);
    end
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK(q[1:0], 2'b00)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    seed = 89030;
    failures = 0;
    cmp_count = 0;
    srst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    sel = 4'hf;
    wdat = 32'h0;
    trig = 1'b0;
    mod_bit = 1'b0;
    mux_v = 4'h0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    foreach (regs[i]) begin
      bus(1'b0, regs[i], 32'h0);
      `CHK(q, 32'h0)
    end
    n_ce = 0;
    repeat (2 * MOD_DIV) begin
      @(posedge clk);
      n_ce += int'(mod_ce);
    end
    `CHK(n_ce, 2)
    run(MODE_SINGLE, 1'b0, 1'b0, 1);
    run(MODE_CONT, 1'b0, 1'b0, 3);
    run(MODE_MULTI, 1'b0, 1'b0, 2);
    run(MODE_TURBO, 1'b0, 1'b0, 2);
    run(MODE_SINGLE, 1'b1, 1'b1, 1);
    end_sim();
  end
endmodule
`default_nettype wire
